// ### inc/brake_consts.svh
`ifndef BRAKE_CONSTS_SVH
`define BRAKE_CONSTS_SVH

// ----------------------------------------------------------------------------
// Clock and time base
// ----------------------------------------------------------------------------
`define CLK_HZ            20000000
`define TICK_MS           1
`define TICK_CYCLES       ((`CLK_HZ / 1000) * `TICK_MS)
`define TIMER_W           20

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define ADDR_W            8
`define OFS_CTRL          8'h00
`define OFS_OPEN_DLY      8'h04
`define OFS_CLOSE_DLY     8'h08
`define OFS_EXCITE        8'h0C
`define OFS_THRESH        8'h10
`define OFS_MONITOR       8'h14
`define OFS_PULSE         8'h18
`define OFS_START_FREQ    8'h1C
`define OFS_STATUS        8'h20
`define NUM_CFG           8
`define IDX_STATUS        8

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define CTRL_MODE_LSB     0
`define CTRL_FOPEN_LSB    2
`define CTRL_FCLOSE_LSB   4
`define CTRL_FREQ_SRC_BIT 6
`define CTRL_TRQ_SRC_BIT  7

// ----------------------------------------------------------------------------
// Reset values (times in ms, speed in rpm, frequency in percent)
// ----------------------------------------------------------------------------
`define RST_CTRL          32'h0000_0000
`define RST_OPEN_DLY      32'h0000_0064
`define RST_CLOSE_DLY     32'h0000_0064
`define RST_EXCITE        32'h0000_0000
`define RST_THRESH        32'h0000_0014
`define RST_MONITOR       32'h0004_93E0
`define RST_PULSE         32'h0000_000A
`define RST_START_FREQ    32'h0000_0000

// ----------------------------------------------------------------------------
// Writable bit masks
// ----------------------------------------------------------------------------
`define MASK_CTRL         32'h0000_00FF
`define MASK_TIME         32'h000F_FFFF
`define MASK_16           32'h0000_FFFF

// ----------------------------------------------------------------------------
// Status word layout
// ----------------------------------------------------------------------------
`define STAT_MOTOR_ON_BIT 0
`define STAT_RAMP_EN_BIT  1
`define STAT_BRAKE_BIT    12

`define RESP_OKAY         2'h0
`define RESP_DECERR       2'h3

`endif

// ### inc/brake_pkg.sv
package brake_pkg;

  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_EXCITE  = 6'h02,
    ST_OPENING = 6'h04,
    ST_RUN     = 6'h08,
    ST_STOP    = 6'h10,
    ST_CLOSING = 6'h20
  } seq_state_t;

  typedef enum logic [1:0] {
    MODE_LOCKED = 2'h0,
    MODE_SEQ    = 2'h1,
    MODE_OPEN   = 2'h2,
    MODE_LINKED = 2'h3
  } brake_mode_t;

  typedef enum logic [1:0] {
    SRC_ZERO = 2'h0,
    SRC_ONE  = 2'h1,
    SRC_PIN  = 2'h2,
    SRC_NPIN = 2'h3
  } bin_src_t;

endpackage

// ### rtl/motor_brake_sequencer.sv
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "brake_consts.svh"

// Contract
// RL1 - Mode 0 keeps brake locked, 1 sequence, 2 always open, 3 interconnect.
// RL2 - Brake opening delay configurable, default 0.1 s.
// RL3 - Brake closing delay configurable, default 0.1 s.
// RL4 - Status word bit 12 shows brake open, readable over the bus.
// RL5 - Excitation build-up time configurable, default 0, magnetizes motor after switch-on.
// RL6 - Selectable binary source forces brake open; default constant 0.
// RL7 - Selectable binary source forces brake closed; default constant 0.
// RL8 - During ramp stops, speed below threshold (20 rpm) starts standstill timers.
// RL9 - Standstill monitoring time configurable, default 300 s.
// RL10 - Pulse suppression delay configurable, default 0.01 s.
// RL11 - Starting frequency applied when starting with brake; above 0 enables slip compensation.
// RL12 - Starting frequency source selectable, default own starting frequency setting.
// RL13 - Starting torque source selectable, default constant 0.
// RL14 - On: excite motor, open brake after excitation, hold until opening delay, run.
// RL15 - Ramp stop closes brake when first of monitoring or pulse delay expires.
// RL16 - After close command keep motor on for closing delay, then switch off.
// RL17 - Coast stop closes brake immediately regardless of speed; the code keeps it open in mode 2 and while force open is active.
// RL18 - Simultaneous force open and force close: close wins.

module motor_brake_sequencer import brake_pkg::*; #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  // AXI4-Lite slave
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [7:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  // Drive commands
  input  wire logic         on_cmd,
  input  wire logic         ramp_stop_normal,
  input  wire logic         ramp_stop_fast,
  input  wire logic         coast_stop,
  // Speed feedback, rpm magnitude
  input  wire logic [15:0]  speed_setpoint,
  input  wire logic [15:0]  speed_actual,
  // Interconnect inputs
  input  wire logic         force_open_in,
  input  wire logic         force_close_in,
  input  wire logic         interconnect_brake_in,
  input  wire logic [15:0]  start_freq_in,
  input  wire logic [15:0]  start_torque_in,
  // Drive and brake outputs
  output logic              brake_open_cmd,
  output logic              motor_on,
  output logic              ramp_enable,
  output logic              slip_comp_en,
  output logic [15:0]       start_freq_out,
  output logic [15:0]       start_torque_out,
  output logic [15:0]       status_word
);

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  localparam logic [31:0] RST_VAL [`NUM_CFG] = '{`RST_CTRL, `RST_OPEN_DLY,
    `RST_CLOSE_DLY, `RST_EXCITE, `RST_THRESH, `RST_MONITOR, `RST_PULSE, `RST_START_FREQ};
  localparam logic [31:0] WR_MASK [`NUM_CFG] = '{`MASK_CTRL, `MASK_TIME,
    `MASK_TIME, `MASK_TIME, `MASK_16, `MASK_TIME, `MASK_TIME, `MASK_16};

  logic [31:0] cfg_reg  [`NUM_CFG];
  logic [31:0] cfg_next [`NUM_CFG];
  logic        wr_fire;
  logic [3:0]  wr_idx;

  logic        awready_reg, awready_next, wready_reg, wready_next;
  logic        aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic        bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
  logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [7:0]  awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic [3:0]  wstrb_reg, wstrb_next;
  logic [3:0]  rd_idx;
  logic [15:0] status_word_reg, status_word_next;
  seq_state_t  state_reg, state_next;

  assign wr_idx = awaddr_reg[5:2];
  assign rd_idx = s_axi_araddr[5:2];

  // Address and data are held separately so the master may offer them in either order.
  always_comb begin
    awready_next = awready_reg;
    wready_next  = wready_reg;
    aw_full_next = aw_full_reg;
    w_full_next  = w_full_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    arready_next = arready_reg;
    rvalid_next  = rvalid_reg;
    rresp_next   = rresp_reg;
    rdata_next   = rdata_reg;
    wr_fire      = 1'b0;
    if (s_axi_awvalid && awready_reg) begin
      awaddr_next  = s_axi_awaddr;
      aw_full_next = 1'b1;
      awready_next = 1'b0;
    end
    if (s_axi_wvalid && wready_reg) begin
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
      w_full_next = 1'b1;
      wready_next = 1'b0;
    end
    if (aw_full_reg && w_full_reg && !bvalid_reg) begin
      bvalid_next = 1'b1;
      if ((awaddr_reg[1:0] == 2'h0) && (awaddr_reg[7:2] < 6'(`NUM_CFG))) begin
        wr_fire    = 1'b1;
        bresp_next = `RESP_OKAY;
      end else begin
        bresp_next = `RESP_DECERR;
      end
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next  = 1'b0;
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      awready_next = 1'b1;
      wready_next  = 1'b1;
    end
    if (s_axi_arvalid && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next  = 1'b1;
      rresp_next   = `RESP_OKAY;
      rdata_next   = 32'h0000_0000;
      if (s_axi_araddr[1:0] != 2'h0 || s_axi_araddr[7:2] > 6'(`IDX_STATUS)) begin
        rresp_next = `RESP_DECERR;
      end else if (rd_idx == 4'(`IDX_STATUS)) begin
        rdata_next = {10'h000, state_reg, status_word_reg};  // [RL4]
      end else begin
        rdata_next = cfg_reg[rd_idx[2:0]];
      end
    end
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= 2'h0;
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= 2'h0;
      rdata_reg   <= 32'h0000_0000;
    end else begin
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
    end
  end

  // Byte enables merge into each configuration word; bits outside the mask read zero.
  for (genvar i = 0; i < `NUM_CFG; i++) begin : g_cfg
    always_comb begin
      cfg_next[i] = cfg_reg[i];
      if (wr_fire && (wr_idx == 4'(i))) begin
        for (int b = 0; b < 4; b++) begin
          if (wstrb_reg[b]) begin
            cfg_next[i][8*b +: 8] = wdata_reg[8*b +: 8];
          end
        end
        cfg_next[i] = cfg_next[i] & WR_MASK[i];
      end
    end

    always_ff @(posedge core_clk) begin
      if (!rst_b) begin
        cfg_reg[i] <= RST_VAL[i];
      end else begin
        cfg_reg[i] <= cfg_next[i];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Configuration fields
  // --------------------------------------------------------------------------
  brake_mode_t              mode;
  bin_src_t                 fopen_src, fclose_src;
  logic [`TIMER_W-1:0]      open_dly, close_dly, excite_time, monitor_time, pulse_time;
  logic [15:0]              thresh, own_start_freq;

  assign mode           = brake_mode_t'(cfg_reg[0][`CTRL_MODE_LSB +: 2]);        // [RL1]
  assign fopen_src      = bin_src_t'(cfg_reg[0][`CTRL_FOPEN_LSB +: 2]);
  assign fclose_src     = bin_src_t'(cfg_reg[0][`CTRL_FCLOSE_LSB +: 2]);
  assign open_dly       = cfg_reg[1][`TIMER_W-1:0];                              // [RL2]
  assign close_dly      = cfg_reg[2][`TIMER_W-1:0];                              // [RL3]
  assign excite_time    = cfg_reg[3][`TIMER_W-1:0];                              // [RL5]
  assign thresh         = cfg_reg[4][15:0];
  assign monitor_time   = cfg_reg[5][`TIMER_W-1:0];                              // [RL9]
  assign pulse_time     = cfg_reg[6][`TIMER_W-1:0];                              // [RL10]
  assign own_start_freq = cfg_reg[7][15:0];

  // --------------------------------------------------------------------------
  // Millisecond tick
  // --------------------------------------------------------------------------
  logic [31:0] div_reg, div_next;
  logic        tick;

  assign tick = (div_reg == 32'(TICK_CYCLES - 1));

  always_comb begin
    div_next = tick ? 32'h0000_0000 : div_reg + 32'h0000_0001;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      div_reg <= 32'h0000_0000;
    end else begin
      div_reg <= div_next;
    end
  end

  // --------------------------------------------------------------------------
  // Sequence control
  // --------------------------------------------------------------------------
  logic                seq_start, seq_done, mon_start, mon_armed, mon_done;
  logic                pls_start, pls_armed, pls_done, stopping, ramp_req;
  logic [`TIMER_W-1:0] seq_load;

  assign stopping = (state_reg == ST_STOP);
  assign ramp_req = ramp_stop_normal || ramp_stop_fast || !on_cmd;
  assign mon_start = stopping && (speed_setpoint < thresh) && !mon_armed;  // [RL8]
  assign pls_start = stopping && (speed_actual < thresh) && !pls_armed;    // [RL8]

  always_comb begin
    state_next = state_reg;
    seq_start  = 1'b0;
    seq_load   = excite_time;
    case (state_reg)
      ST_IDLE: begin
        if (on_cmd && !coast_stop && !ramp_stop_normal && !ramp_stop_fast) begin
          state_next = ST_EXCITE;                                         // [RL14]
          seq_start  = 1'b1;
          seq_load   = excite_time;                                       // [RL5]
        end
      end
      ST_EXCITE: begin
        if (ramp_req) begin
          state_next = ST_IDLE;
        end else if (seq_done) begin
          state_next = ST_OPENING;                                        // [RL14]
          seq_start  = 1'b1;
          seq_load   = open_dly;                                          // [RL2]
        end
      end
      ST_OPENING: begin
        if (ramp_req) begin
          state_next = ST_STOP;
        end else if (seq_done) begin
          state_next = ST_RUN;                                            // [RL14]
        end
      end
      ST_RUN: begin
        if (ramp_req) begin
          state_next = ST_STOP;
        end
      end
      ST_STOP: begin
        if (mon_done || pls_done) begin
          state_next = ST_CLOSING;                                        // [RL15]
          seq_start  = 1'b1;
          seq_load   = close_dly;                                         // [RL3]
        end
      end
      ST_CLOSING: begin
        if (seq_done) begin
          state_next = ST_IDLE;                                           // [RL16]
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (coast_stop) begin
      state_next = ST_IDLE;                                               // [RL17]
      seq_start  = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  ms_timer #(.W(`TIMER_W)) u_seq_timer (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .start    (seq_start),
    .hold     (1'b1),
    .tick     (tick),
    .load_val (seq_load),
    .armed    (),
    .done     (seq_done)
  );

  ms_timer #(.W(`TIMER_W)) u_monitor_timer (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .start    (mon_start),
    .hold     (stopping),
    .tick     (tick),
    .load_val (monitor_time),
    .armed    (mon_armed),
    .done     (mon_done)
  );

  ms_timer #(.W(`TIMER_W)) u_pulse_timer (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .start    (pls_start),
    .hold     (stopping),
    .tick     (tick),
    .load_val (pulse_time),
    .armed    (pls_armed),
    .done     (pls_done)
  );

  // --------------------------------------------------------------------------
  // Brake command and drive outputs
  // --------------------------------------------------------------------------
  function automatic logic pick_src(input bin_src_t src, input logic pin);
    case (src)
      SRC_ZERO: pick_src = 1'b0;
      SRC_ONE:  pick_src = 1'b1;
      SRC_PIN:  pick_src = pin;
      SRC_NPIN: pick_src = !pin;
      default:  pick_src = 1'b0;
    endcase
  endfunction

  logic        seq_open, brake_next, motor_next, ramp_next, slip_next, starting;
  logic [15:0] freq_sel, freq_next, torque_next;
  logic        brake_reg, motor_reg, ramp_reg, slip_reg;
  logic [15:0] freq_reg, torque_reg;

  assign seq_open = (state_next == ST_OPENING) || (state_next == ST_RUN) ||
                    (state_next == ST_STOP);
  assign starting = (state_next == ST_EXCITE) || (state_next == ST_OPENING);

  // Outputs follow state_next so they change on the same edge as the state.
  always_comb begin
    case (mode)
      MODE_LOCKED: brake_next = 1'b0;                                     // [RL1]
      MODE_SEQ:    brake_next = seq_open;                                 // [RL1]
      MODE_OPEN:   brake_next = 1'b1;                                     // [RL1]
      MODE_LINKED: brake_next = interconnect_brake_in && !coast_stop;     // [RL1]
      default:     brake_next = 1'b0;
    endcase
    if (pick_src(fopen_src, force_open_in)) begin
      brake_next = 1'b1;                                                  // [RL6]
    end
    if (pick_src(fclose_src, force_close_in)) begin
      brake_next = 1'b0;                                                  // [RL7] [RL18]
    end
    motor_next  = (state_next != ST_IDLE);
    ramp_next   = (state_next == ST_RUN);
    freq_sel    = cfg_reg[0][`CTRL_FREQ_SRC_BIT] ? start_freq_in : own_start_freq;  // [RL12]
    freq_next   = starting ? freq_sel : 16'h0000;                         // [RL11]
    slip_next   = (freq_sel != 16'h0000);                                 // [RL11]
    torque_next = (starting && cfg_reg[0][`CTRL_TRQ_SRC_BIT]) ? start_torque_in
                                                              : 16'h0000; // [RL13]
    status_word_next = 16'h0000;
    status_word_next[`STAT_BRAKE_BIT]    = brake_next;                    // [RL4]
    status_word_next[`STAT_MOTOR_ON_BIT] = motor_next;
    status_word_next[`STAT_RAMP_EN_BIT]  = ramp_next;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      brake_reg       <= 1'b0;
      motor_reg       <= 1'b0;
      ramp_reg        <= 1'b0;
      slip_reg        <= 1'b0;
      freq_reg        <= 16'h0000;
      torque_reg      <= 16'h0000;
      status_word_reg <= 16'h0000;
    end else begin
      brake_reg       <= brake_next;
      motor_reg       <= motor_next;
      ramp_reg        <= ramp_next;
      slip_reg        <= slip_next;
      freq_reg        <= freq_next;
      torque_reg      <= torque_next;
      status_word_reg <= status_word_next;
    end
  end

  assign brake_open_cmd   = brake_reg;
  assign motor_on         = motor_reg;
  assign ramp_enable      = ramp_reg;
  assign slip_comp_en     = slip_reg;
  assign start_freq_out   = freq_reg;
  assign start_torque_out = torque_reg;
  assign status_word      = status_word_reg;
  assign s_axi_awready    = awready_reg;
  assign s_axi_wready     = wready_reg;
  assign s_axi_bvalid     = bvalid_reg;
  assign s_axi_bresp      = bresp_reg;
  assign s_axi_arready    = arready_reg;
  assign s_axi_rvalid     = rvalid_reg;
  assign s_axi_rresp      = rresp_reg;
  assign s_axi_rdata      = rdata_reg;

endmodule

// ### rtl/ms_timer.sv
`timescale 1ns/100ps
`include "brake_consts.svh"

module ms_timer import brake_pkg::*; #(
  parameter int W = `TIMER_W
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  // Control
  input  wire logic         start,
  input  wire logic         hold,
  input  wire logic         tick,
  input  wire logic [W-1:0] load_val,
  // Status
  output logic              armed,
  output logic              done
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic         armed_reg;
  logic         armed_next;

  // Dropping hold aborts a running interval so a restart always begins fresh.
  always_comb begin
    count_next = count_reg;
    armed_next = armed_reg;
    if (!hold) begin
      armed_next = 1'b0;
    end else if (start) begin
      count_next = load_val;
      armed_next = 1'b1;
    end else if (armed_reg && tick && (count_reg != '0)) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      count_reg <= '0;
      armed_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      armed_reg <= armed_next;
    end
  end

  assign armed = armed_reg;
  assign done  = armed_reg && (count_reg == '0);

endmodule

// ### testbench/brake_chk.sv
`timescale 1ns/100ps
// ----
// Bus and sequence checks
// ----
module brake_chk (
  input wire logic        core_clk, rst_b, coast_stop,
  input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic        s_axi_bvalid, s_axi_arvalid, s_axi_arready,
  input wire logic        s_axi_rvalid, s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        motor_on, ramp_enable, brake_open_cmd,
  input wire logic [15:0] status_word
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_coast_off: assert property (coast_stop |=> !motor_on)
    else $error("motor on after coast stop");
  a_ramp_motor: assert property ($rose(ramp_enable) |-> motor_on)
    else $error("ramp without motor");
  a_motor_first: assert property ($rose(motor_on) |-> !ramp_enable)
    else $error("ramp before excitation");
  a_stat_brake: assert property (status_word[12] == brake_open_cmd)
    else $error("status brake bit wrong");
  a_read_ans: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_write_ans: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule

// ### testbench/brake_relay_model.sv
`timescale 1ns/100ps
// ----
// Relay, brake and shaft
// ----
module brake_relay_model #(
  parameter int LAG = 3
) (
  input wire logic        core_clk,
  input wire logic        brake_open_cmd,
  input wire logic [15:0] speed_setpoint,
  output logic     [15:0] speed_actual
);
  // The shaft turns only once relay and brake have released.
  logic [3:0] cnt = 4'h0;
  always @(posedge core_clk) cnt <= !brake_open_cmd ? 4'h0 : (cnt == 4'(LAG)) ? cnt : cnt + 4'h1;
  assign speed_actual = (cnt == 4'(LAG)) ? speed_setpoint : 16'h0000;
endmodule

// ### testbench/tb.sv
`timescale 1ns/100ps
`include "brake_consts.svh"
`define CHK(n, e, v) begin comparisons++; if ((v) !== (e)) begin n_fail++; \
  $display("BAD %s exp %0h got %0h", n, e, v); end end
module tb;
  logic        core_clk, rst_b, on_cmd, ramp_stop_normal, ramp_stop_fast, coast_stop;
  logic        force_open_in, force_close_in, interconnect_brake_in, slip_comp_en;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        brake_open_cmd, motor_on, ramp_enable;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [15:0] speed_setpoint, speed_actual, start_freq_in, start_torque_in;
  logic [15:0] start_freq_out, start_torque_out, status_word;
  int          n_fail, comparisons;
  motor_brake_sequencer #(.TICK_CYCLES(4)) motor_brake_sequencer_inst (.*);
  brake_relay_model brake_relay_model_inst (.*);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task complete_run;
    if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task hang;
    n_fail++;
    complete_run();
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hF};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
    if (i == 50) hang();
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int i;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    {rd, rs} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
    if (i == 50) hang();
  endtask
  task automatic wait_lv(ref logic s, input logic v, output int n);
    for (n = 0; n < 400 && s !== v; n++) @(posedge core_clk);
    if (n == 400) hang();
  endtask
  task automatic t_regs;
    logic [31:0] rv [8] = '{32'h0, 32'h64, 32'h64, 32'h0, 32'h14, 32'h493E0, 32'hA, 32'h0};
    for (int k = 0; k < 8; k++) begin
      axi_rd(8'(k * 4));
      `CHK("reset value", rv[k], rd)
    end
    axi_rd(8'h24);
    `CHK("unmapped resp", 2'h3, rs)
    axi_wr(`OFS_STATUS, 32'h1000);
    `CHK("status write resp", 2'h3, rs)
  endtask
  task automatic t_seq;
    int n;
    axi_wr(`OFS_EXCITE, 32'h2);
    axi_wr(`OFS_OPEN_DLY, 32'h3);
    axi_wr(`OFS_CLOSE_DLY, 32'h3);
    axi_wr(`OFS_MONITOR, 32'h2);
    axi_wr(`OFS_PULSE, 32'h32);
    axi_wr(`OFS_CTRL, 32'hC1);
    {start_freq_in, start_torque_in} <= {16'h0050, 16'h1234};
    {speed_setpoint, on_cmd} <= {16'h0200, 1'b1};
    wait_lv(motor_on, 1'b1, n);
    `CHK("start freq", 16'h0050, start_freq_out)
    `CHK("start torque", 16'h1234, start_torque_out)
    wait_lv(brake_open_cmd, 1'b1, n);
    `CHK("excite cycles", 1'b1, n inside {[4:10]})
    wait_lv(ramp_enable, 1'b1, n);
    `CHK("open cycles", 1'b1, n inside {[8:14]})
    axi_rd(`OFS_STATUS);
    `CHK("status brake bit", 1'b1, rd[12])
    {speed_setpoint, ramp_stop_normal} <= {16'h0, 1'b1};
    wait_lv(brake_open_cmd, 1'b0, n);
    `CHK("monitor cycles", 1'b1, n inside {[4:12]})
    `CHK("motor held", 1'b1, motor_on)
    wait_lv(motor_on, 1'b0, n);
    `CHK("close cycles", 1'b1, n inside {[8:14]})
  endtask
  task automatic t_coast;
    int n;
    {speed_setpoint, ramp_stop_normal} <= {16'h0200, 1'b0};
    wait_lv(ramp_enable, 1'b1, n);
    coast_stop <= 1'b1;
    repeat (2) @(posedge core_clk);
    `CHK("coast brake", 1'b0, brake_open_cmd)
    `CHK("coast motor", 1'b0, motor_on)
    {coast_stop, on_cmd} <= 2'h0;
  endtask
  // Bits 7:0 control word, 8 expected brake, 9 open pin, 10 close pin.
  task automatic t_force;
    logic [10:0] tv [7] = '{11'h000, 11'h102, 11'h103, 11'h104, 11'h014, 11'h308, 11'h422};
    interconnect_brake_in <= 1'b1;
    foreach (tv[k]) begin
      {force_close_in, force_open_in} <= tv[k][10:9];
      axi_wr(`OFS_CTRL, {24'h0, tv[k][7:0]});
      `CHK("brake by mode", tv[k][8], brake_open_cmd)
    end
    axi_wr(`OFS_START_FREQ, 32'h5);
    `CHK("slip comp", 1'b1, slip_comp_en)
  endtask
  initial begin
    {rst_b, on_cmd, ramp_stop_normal, ramp_stop_fast, coast_stop} = '0;
    {force_open_in, force_close_in, interconnect_brake_in} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {speed_setpoint, start_freq_in, start_torque_in} = '0;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_seq();
    t_coast();
    t_force();
    complete_run();
  end
endmodule
bind motor_brake_sequencer brake_chk brake_chk_inst (.*);
